// ### sfsfe_front_end.sv
// Serial flash front end: SPI frame engine, protection, geometry and Wishbone registers.
// Assumes spi_clk, spi_cs_n and io lines are asynchronous pins sampled by mclk.
//
// Behaviour
// - single mode samples input line on rising edges
// - single mode drives output line on falling edges
// - dual/quad lines bidirectional, same edge roles
// - dual uses lines 0-1, quad uses 0-3
// - deselected means ignore bus, lines high impedance
// - deselect never aborts a running internal cycle
// - no instruction before first select falling edge
// - protect pin plus lock rejects status writes
// - range bits guard array from program, erase
// - protect pin function only outside quad mode
// - only SPI modes 0 and 3 supported
// - page program writes 1 to 256 bytes
// - programming only clears bits, per page
// - erase per sector, block, chip; never page
// - 8 MiB, 2048 sectors, 128 blocks
// - 24-bit addresses, 4 KiB sectors, 16 per block
// - lockable one-time 512-byte security sector
`timescale 1ns/1ps
module sfsfe_front_end (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      spi_clk,
  input  wire logic                      spi_cs_n,
  input  wire logic [3:0]                io_line_in,
  output logic      [3:0]                io_line_out,
  output logic      [3:0]                io_line_oe_n,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [sfsfe_pkg::WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o
);
  import sfsfe_pkg::*;

  // State of the block in one record, all but the security sector contents.
  typedef struct packed {
    logic [5:0]      s1;     // First synchroniser stage.
    logic [5:0]      s2;     // Second synchroniser stage.
    logic            sclk_d; // Previous synchronised clock.
    logic            cs_d;   // Previous synchronised select.
    logic            frame;  // A frame is open.
    logic [1:0]      fw;     // Width latched at frame start.
    sfsfe_phase_type ph;     // Frame phase.
    logic [2:0]      bits;   // Bits gathered in current byte.
    logic [7:0]      in_sh;  // Input shifter.
    logic [7:0]      op;     // Instruction of the frame.
    logic [1:0]      abyte;  // Address bytes taken.
    logic [23:0]     addr;   // Byte address.
    logic [8:0]      pcount; // Data bytes of the frame.
    logic [7:0]      out_sh; // Output shifter.
    logic [3:0]      io_o;   // Driven line levels.
    logic [3:0]      oe_n;   // Line enables, low drives.
    logic [3:0]      bp;     // Protect range bits.
    logic            lock;   // Status lock bit.
    logic            busy;   // Internal cycle running.
    logic [15:0]     bcnt;   // Busy cycles left.
    logic            perr;   // Sticky refusal flag.
    logic [1:0]      width;  // Width chosen by software.
    logic [15:0]     blen;   // Busy length in mclk cycles.
    logic            otpl;   // Security sector locked.
    logic [7:0]      rx;     // Last received data byte.
    logic            rxnew;  // Unread received byte.
    logic [15:0]     fifo;   // Two read-data entries.
    logic [1:0]      fcnt;   // Entries held.
    logic            frd;    // Head entry index.
    logic            ack;    // Wishbone acknowledge.
    logic [31:0]     dat;    // Wishbone read data.
  } sfsfe_state_type;

  sfsfe_state_type st;
  sfsfe_state_type next_st;

  logic [7:0] otp_mem [0:OTP_BYTES-1]; // Security sector contents.
  logic       otp_we;                  // Security sector write strobe.
  logic [8:0] otp_wa;                  // Security sector write address.
  logic [7:0] otp_wd;                  // Security sector write data.
  logic       sr_block;                // Status write refused by the pin.

  // Protected when the block lies in the top range chosen by the range bits.
  function automatic logic prot_hit(input logic [3:0] bp, input logic [6:0] blk);
    logic [7:0] first;
    first = BLOCKS - (8'h01 << (bp - 4'h1));
    if (bp == 4'h0) begin
      prot_hit = 1'b0;
    end else if (bp[3]) begin
      prot_hit = 1'b1;
    end else begin
      prot_hit = ({1'b0, blk} >= first);
    end
  endfunction : prot_hit

  // Next state of the whole block.
  always_comb begin
    logic       sck, csn, rise, fall, cs_fall, cs_rise, done, load, pop, push;
    logic       acc, pin_ok, arr_op, hit;
    logic [3:0] io, nb, sum;
    logic [7:0] shv, nxt, head, stat_b;
    logic [23:0] na;
    next_st  = st;
    otp_we   = 1'b0;
    otp_wa   = st.addr[8:0];
    otp_wd   = 8'h00;
    sr_block = 1'b0;
    load     = 1'b0;
    pop      = 1'b0;
    push     = 1'b0;
    na       = st.addr;
    hit      = 1'b0;
    pin_ok   = 1'b0;
    arr_op   = 1'b0;
    // The first stage feeds only the second.
    next_st.s1 = {io_line_in, spi_cs_n, spi_clk};
    next_st.s2 = st.s1;
    sck  = st.s2[0];
    csn  = st.s2[1];
    io   = st.s2[5:2];
    next_st.sclk_d = sck;
    next_st.cs_d   = csn;
    // Edges of the link clock; either idle level works, giving modes 0 and 3.
    rise    = sck & ~st.sclk_d;
    fall    = ~sck & st.sclk_d;
    // The select history resets low, so a high level must be seen first.
    cs_fall = ~csn & st.cs_d;
    cs_rise = csn & ~st.cs_d;
    stat_b  = 8'h00;
    stat_b[ST_BUSY] = st.busy;
    stat_b[ST_BP+:4] = st.bp;
    stat_b[ST_LOCK] = st.lock;
    head = st.frd ? st.fifo[15:8] : st.fifo[7:0];

    // Bits per edge for the frame's width; other codes fall back to one line.
    unique case (st.fw)
      W_DUAL: begin
        nb  = 4'h2;
        shv = {st.in_sh[5:0], io[1:0]};
      end
      W_QUAD: begin
        nb  = 4'h4;
        shv = {st.in_sh[3:0], io};
      end
      default: begin
        nb  = 4'h1;
        shv = {st.in_sh[6:0], io[0]};
      end
    endcase
    sum  = {1'b0, st.bits} + nb;
    done = sum[3];

    // The internal cycle counts down whatever the select line does.
    if (st.busy) begin
      next_st.bcnt = st.bcnt - 16'h1;
      if (st.bcnt <= 16'h1) begin
        next_st.busy = 1'b0;
      end
    end

    // Wishbone slave: one request at a time; a buffer write stalls while the buffer is full.
    acc = wb_cyc_i & wb_stb_i & ~st.ack;
    if (wb_we_i && wb_adr_i == A_TX && st.fcnt == 2'h2) begin
      acc = 1'b0;
    end
    next_st.ack = acc;
    if (acc && wb_we_i) begin
      unique case (wb_adr_i)
        A_CTRL: begin
          if (wb_sel_i[0]) begin
            next_st.width = wb_dat_i[1:0];
            next_st.otpl  = st.otpl | wb_dat_i[CT_OTPL];
          end
        end
        A_BLEN: begin
          if (wb_sel_i[0]) begin
            next_st.blen[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            next_st.blen[15:8] = wb_dat_i[15:8];
          end
        end
        A_STAT: begin
          // Writing one clears the refusal flag.
          if (wb_sel_i[1] && wb_dat_i[STAT_ERR]) begin
            next_st.perr = 1'b0;
          end
        end
        A_TX: begin
          push = wb_sel_i[0];
        end
        default: begin
          // Unmapped writes are acknowledged and dropped.
        end
      endcase
    end else if (acc) begin
      unique case (wb_adr_i)
        A_CTRL: next_st.dat = {27'h0, st.otpl, 2'h0, st.width};
        A_BLEN: next_st.dat = {16'h0, st.blen};
        A_STAT: next_st.dat = {8'h0, st.op, 5'h0, st.frame, st.rxnew, st.perr, stat_b};
        A_ADDR: next_st.dat = {8'h0, st.addr};
        A_TX:   next_st.dat = {30'h0, st.fcnt};
        A_RX: begin
          next_st.dat   = {23'h0, st.rxnew, st.rx};
          next_st.rxnew = 1'b0;
        end
        // Sector and block of the current address.
        A_GEO:  next_st.dat = {st.pcount, st.addr[22:16], 5'h0, st.addr[22:12]};
        default: next_st.dat = 32'h0;
      endcase
    end

    // Frame engine; a deselect ends the frame before any edge is looked at.
    if (csn) begin
      next_st.oe_n = 4'hF;
      next_st.io_o = 4'h0;
      next_st.ph   = PH_IDLE;
      next_st.frame = 1'b0;
    end
    if (cs_rise && st.frame) begin
      // The protect pin only counts outside quad frames.
      pin_ok = (st.fw == W_QUAD) | io[2];
      arr_op = ((st.op == OP_PP || st.op == OP_OTPP) && st.ph == PH_DATA &&
                st.pcount != 9'h0) ||
               ((st.op == OP_SE || st.op == OP_BE) && st.ph == PH_DATA) ||
               (st.op == OP_CE);
      // The security sector lies outside the range bits; its own lock refuses it instead.
      hit = (st.op == OP_CE)   ? (st.bp != 4'h0) :
            (st.op == OP_OTPP) ? st.otpl : prot_hit(st.bp, st.addr[22:16]);
      if (st.op == OP_WRSR && st.pcount != 9'h0) begin
        if (st.lock && !pin_ok) begin
          sr_block     = 1'b1;
          next_st.perr = 1'b1;
        end else if (st.busy) begin
          next_st.perr = 1'b1;
        end else begin
          next_st.bp   = st.rx[ST_BP+:4];
          next_st.lock = st.rx[ST_LOCK];
          next_st.busy = 1'b1;
          next_st.bcnt = (st.blen == 16'h0) ? 16'h1 : st.blen;
        end
      end else if (arr_op) begin
        if (st.busy || hit) begin
          next_st.perr = 1'b1;
        end else begin
          next_st.busy = 1'b1;
          next_st.bcnt = (st.blen == 16'h0) ? 16'h1 : st.blen;
        end
      end
    end else if (cs_fall) begin
      next_st.frame  = 1'b1;
      next_st.fw     = st.width;
      next_st.ph     = PH_CMD;
      next_st.bits   = 3'h0;
      next_st.abyte  = 2'h0;
      next_st.pcount = 9'h0;
      next_st.op     = 8'h00;
    end else if (st.frame && !csn && rise) begin
      next_st.in_sh = shv;
      next_st.bits  = sum[2:0];
      if (done) begin
        unique case (st.ph)
          PH_CMD: begin
            // First byte of the frame is the instruction.
            next_st.op = shv;
            if (shv == OP_RDSR) begin
              next_st.ph = PH_OUT;
              load       = 1'b1;
            end else if (shv == OP_PP || shv == OP_READ || shv == OP_SE || shv == OP_BE ||
                         shv == OP_OTPP || shv == OP_OTPR) begin
              next_st.ph = PH_ADDR;
            end else if (shv == OP_WRSR || shv == OP_CE) begin
              next_st.ph = PH_DATA;
            end else begin
              next_st.ph = PH_IDLE;
            end
          end
          PH_ADDR: begin
            // Three address bytes, top bit dropped so the 8 MiB array wraps.
            na            = {1'b0, st.addr[14:0], shv};
            next_st.addr  = na;
            next_st.abyte = st.abyte + 2'h1;
            if (st.abyte == 2'h2) begin
              if (st.op == OP_READ || st.op == OP_OTPR) begin
                next_st.ph = PH_OUT;
                load       = 1'b1;
              end else begin
                next_st.ph = PH_DATA;
              end
            end
          end
          PH_DATA: begin
            if (st.pcount != PAGE_BYTES) begin
              next_st.pcount = st.pcount + 9'h1;
            end
            next_st.rx    = shv;
            next_st.rxnew = 1'b1;
            // The column wraps inside the page.
            next_st.addr[7:0] = st.addr[7:0] + 8'h01;
            if (st.op == OP_OTPP && !st.otpl) begin
              otp_we = 1'b1;
              otp_wd = otp_mem[st.addr[8:0]] & shv;
            end
          end
          PH_OUT: begin
            if (st.op != OP_RDSR) begin
              na           = {1'b0, st.addr[22:0] + 23'h1};
              next_st.addr = na;
            end
            load = 1'b1;
          end
          PH_IDLE: begin
            // Unknown instruction: the rest of the frame is ignored.
          end
          default: next_st.ph = PH_IDLE;
        endcase
      end
    end else if (st.frame && !csn && fall && st.ph == PH_OUT) begin
      unique case (st.fw)
        W_DUAL: begin
          next_st.io_o   = {2'h0, st.out_sh[7:6]};
          next_st.oe_n   = 4'hC;
          next_st.out_sh = {st.out_sh[5:0], 2'h0};
        end
        W_QUAD: begin
          next_st.io_o   = st.out_sh[7:4];
          next_st.oe_n   = 4'h0;
          next_st.out_sh = {st.out_sh[3:0], 4'h0};
        end
        default: begin
          next_st.io_o   = {2'h0, st.out_sh[7], 1'b0};
          next_st.oe_n   = 4'hD;
          next_st.out_sh = {st.out_sh[6:0], 1'b0};
        end
      endcase
    end

    // Next byte to shift out; array reads come from the software buffer.
    if (st.op == OP_RDSR) begin
      nxt = stat_b;
    end else if (st.op == OP_OTPR) begin
      nxt = otp_mem[na[8:0]];
    end else begin
      nxt = (st.fcnt != 2'h0) ? head : ERASED;
      pop = load && (st.fcnt != 2'h0);
    end
    if (load) begin
      next_st.out_sh = (shv == OP_RDSR && st.ph == PH_CMD) ? stat_b : nxt;
    end

    // Two-entry buffer between register writes and the serial reader.
    if (push) begin
      if (st.frd ^ st.fcnt[0]) begin
        next_st.fifo[15:8] = wb_dat_i[7:0];
      end else begin
        next_st.fifo[7:0] = wb_dat_i[7:0];
      end
    end
    if (pop) begin
      next_st.frd = ~st.frd;
    end
    next_st.fcnt = st.fcnt + {1'b0, push} - {1'b0, pop};
  end

  // State register and security sector, frozen while the enable is low.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st         <= '0;
      st.oe_n    <= 4'hF;
      st.blen    <= BLEN_RST;
      for (int i = 0; i < OTP_BYTES; i++) begin
        otp_mem[i] <= ERASED;
      end
    end else if (ce) begin
      st <= next_st;
      if (otp_we) begin
        otp_mem[otp_wa] <= otp_wd;
      end
    end
  end

  assign io_line_out  = st.io_o;
  assign io_line_oe_n = st.oe_n;
  assign wb_dat_o     = st.dat;
  assign wb_ack_o     = st.ack;

  // Checks on the behaviour above.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || !ce);

  a_desel_hiz: assert property (!st.frame |-> st.oe_n == 4'hF)
    else $error("lines driven outside a frame");
  a_width_lines: assert property (st.fw != W_QUAD |-> st.oe_n[3:2] == 2'h3)
    else $error("upper lines driven outside quad");
  a_busy_runs: assert property (st.busy && st.bcnt > 16'h1 |=> st.busy)
    else $error("internal cycle cut short");
  a_busy_ends: assert property (st.busy && st.bcnt == 16'h1 |=> !st.busy)
    else $error("busy outlived its length");
  a_frame_start: assert property ($rose(st.frame) |-> $past(st.cs_d) && !$past(st.s2[1]))
    else $error("frame opened without select falling");
  a_sr_locked: assert property (sr_block |=> st.bp == $past(st.bp) && st.perr)
    else $error("locked status write took effect");
  a_page_cap: assert property (st.pcount <= PAGE_BYTES)
    else $error("page byte count over limit");
  a_otp_locked: assert property (otp_we |-> !st.otpl)
    else $error("locked security sector written");
  a_rise_sample: assert property (st.frame && !st.s2[1] && st.s2[0] && !st.sclk_d &&
                                  st.fw == W_SINGLE |=> st.in_sh[0] == $past(st.s2[2]))
    else $error("input bit not sampled on rising edge");
  a_fall_drive: assert property (st.frame && !st.s2[1] && !st.s2[0] && st.sclk_d &&
                                 st.ph == PH_OUT && st.fw == W_SINGLE
                                 |=> st.io_o[1] == $past(st.out_sh[7]) && st.oe_n == 4'hD)
    else $error("output bit not driven on falling edge");
  a_ack_pulse: assert property (st.ack |=> !st.ack)
    else $error("acknowledge held two cycles");
  a_fifo_bound: assert property (st.fcnt <= 2'h2)
    else $error("buffer count over two");

endmodule : sfsfe_front_end

// ### sfsfe_pkg.sv
// Shared constants and types of the serial flash front end.
// Assumes a Wishbone classic master and an SPI master that owns the link clock.
package sfsfe_pkg;

  // Wishbone address width and register byte offsets.
  localparam int         WB_AW   = 8;
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_BLEN  = 8'h04;
  localparam logic [7:0] A_STAT  = 8'h08;
  localparam logic [7:0] A_ADDR  = 8'h0C;
  localparam logic [7:0] A_TX    = 8'h10;
  localparam logic [7:0] A_RX    = 8'h14;
  localparam logic [7:0] A_GEO   = 8'h18;

  // Transfer widths held in the control register.
  localparam logic [1:0] W_SINGLE = 2'h0;
  localparam logic [1:0] W_DUAL   = 2'h1;
  localparam logic [1:0] W_QUAD   = 2'h2;

  // Instruction codes understood by the front end.
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_SE    = 8'h20;
  localparam logic [7:0] OP_OTPP  = 8'h42;
  localparam logic [7:0] OP_OTPR  = 8'h48;
  localparam logic [7:0] OP_CE    = 8'hC7;
  localparam logic [7:0] OP_BE    = 8'hD8;

  // Array geometry: page size, block count and security sector size.
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [7:0] BLOCKS     = 8'h80;
  localparam int         OTP_BYTES  = 512;
  localparam logic [7:0] ERASED     = 8'hFF;

  // Status byte field positions.
  localparam int ST_BUSY = 0;
  localparam int ST_BP   = 2;
  localparam int ST_LOCK = 7;

  // Control and status field positions and the busy length reset value.
  localparam int          CT_OTPL  = 4;
  localparam int          STAT_ERR = 8;
  localparam logic [15:0] BLEN_RST = 16'h0100;

  // Frame phases of the serial engine.
  typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_DATA, PH_OUT} sfsfe_phase_type;

endpackage : sfsfe_pkg

// ### sfsfe_host_model.sv
// Host side SPI master model that drives the link of the serial flash front end.
// Assumes the bench calls frame() one at a time and sets wid, mode3 and wp_n between frames.
`timescale 1ns/1ps
module sfsfe_host_model (
  output logic            spi_clk,
  output logic            spi_cs_n,
  output logic [3:0]      io_line_in,
  input  wire logic [3:0] io_line_out,
  input  wire logic [3:0] io_line_oe_n
);
  logic [7:0] txb[$];  // Bytes sent in the next frame, instruction first.
  logic [7:0] rxb[$];  // Bytes seen on the lines, one per byte slot.
  logic [3:0] drv;     // Levels the host puts on lines the device leaves alone.
  logic [3:0] used;    // Lines the device drove during the last frame.
  logic [1:0] wid;     // Frame width: 0 single, 1 dual, 2 quad.
  logic       mode3;   // Clock idles high when set.
  logic       wp_n;    // Protect pin level outside quad frames.

  // Each line shows the device's level where it drives and the host's level elsewhere.
  assign io_line_in = (io_line_out & ~io_line_oe_n) | (drv & io_line_oe_n);

  // Select starts low on purpose, so the first frame has no falling edge on it.
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b0;
    drv = 4'hF;
    wid = 2'h0;
    mode3 = 1'b0;
    wp_n = 1'b1;
  end

  // One frame: data changes with the clock low, the device samples on the rise, and the
  // host takes the device's bits just before the next fall, where they have settled.
  task automatic frame(input int n);
    logic [7:0] t;
    logic [7:0] r;
    logic [3:0] v;
    int         k;
    k = 1 << wid;
    rxb.delete();
    used = 4'h0;
    #1 spi_clk = mode3;
    #16 spi_cs_n = 1'b0;
    for (int b = 0; b < n; b++) begin
      t = (b < txb.size()) ? txb[b] : 8'h00;
      for (int e = 0; e < 8 / k; e++) begin
        spi_clk = 1'b0;
        v = 4'(t >> (8 - k));
        // Released lines toggle so that a stale level is never read as data.
        drv = (wid == 2'h2) ? v : {e[0], wp_n, (wid == 2'h1) ? v[1] : ~e[0], v[0]};
        t = 8'(t << k);
        #16 spi_clk = 1'b1;
        #16 r = 8'((r << k) | ((wid == 2'h0) ? {3'h0, io_line_in[1]} :
                                 (io_line_in & 4'((1 << k) - 1))));
        used = used | ~io_line_oe_n;
      end
      rxb.push_back(r);
    end
    if (!mode3) spi_clk = 1'b0;
    #16 spi_cs_n = 1'b1;
    #24;
  endtask : frame
endmodule : sfsfe_host_model

// ### tb_top.sv
// Self-checking bench of the serial flash front end over Wishbone and the SPI link.
// Assumes the host model owns the link pins; the bench owns mclk, reset and the bus.
`timescale 1ns/1ps
module tb_top;
  import sfsfe_pkg::*;
  logic        mclk = 1'b0;        // System clock, 4 ns period.
  logic        rst = 1'b1;         // Synchronous reset, active high.
  logic        spi_clk;            // Link clock from the host model.
  logic        spi_cs_n;           // Select from the host model.
  logic [3:0]  io_line_in;         // Resolved line levels.
  logic [3:0]  io_line_out;        // Device line levels.
  logic [3:0]  io_line_oe_n;       // Device line enables, low drives.
  logic        wb_cyc_i = 1'b0;    // Bus cycle.
  logic        wb_stb_i = 1'b0;    // Bus strobe.
  logic        wb_we_i = 1'b0;     // Bus direction.
  logic [7:0]  wb_adr_i = 8'h00;   // Bus byte address.
  logic [3:0]  wb_sel_i = 4'h0;    // Bus byte lanes.
  logic [31:0] wb_dat_i = 32'h0;   // Bus write data.
  logic [31:0] wb_dat_o;           // Bus read data.
  logic        wb_ack_o;           // Bus acknowledge.
  int          n_fail = 0;         // Mismatches seen.
  int          samples_checked = 0; // Comparisons made.

  sfsfe_front_end uut (.mclk(mclk), .rst(rst), .ce(1'b1), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .io_line_in(io_line_in), .io_line_out(io_line_out),
    .io_line_oe_n(io_line_oe_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

  sfsfe_host_model host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .io_line_in(io_line_in),
    .io_line_out(io_line_out), .io_line_oe_n(io_line_oe_n));

  // The clock toggles every half period.
  always #2 mclk = ~mclk;

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One classic cycle; the request holds until ack is sampled high, then drops.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int t;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 2000);
    r = wb_dat_o;
    chk(32'(t < 2000), 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // Writes one register.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  // Reads one register and compares the bits under a mask.
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask : rdc

  // Runs a frame; once select is high again every line must be released.
  task automatic go(input int n);
    host.frame(n);
    chk(32'(io_line_oe_n), 32'hF);
  endtask : go

  // Runs an array or status operation, then checks busy, refusal and status.
  task automatic op(input int n, input logic refused, input logic [7:0] st);
    go(n);
    if (!refused) rdc(A_STAT, 32'h1, 32'h1);
    repeat (24) @(posedge mclk);
    rdc(A_STAT, 32'h1FF, {23'h0, refused, st});
    wr(A_STAT, 32'h100);
  endtask : op

  // Main sequence.
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rdc(A_CTRL, 32'hFFFFFFFF, 32'h0);
    rdc(A_BLEN, 32'hFFFFFFFF, 32'h100);
    wr(8'h1C, 32'h5);
    rdc(8'h1C, 32'hFFFFFFFF, 32'h0);
    host.txb = {OP_WRSR, 8'h3C};
    go(2);
    rdc(A_STAT, 32'hFF, 32'h0);
    wr(A_BLEN, 32'h10);
    host.txb = {OP_WRSR, 8'h0C};
    op(2, 1'b0, 8'h0C);
    // Status read in single, dual, quad and single with the clock idling high.
    for (int w = 0; w < 4; w++) begin
      wr(A_CTRL, 32'(w % 3));
      host.wid = 2'(w % 3);
      host.mode3 = (w == 3);
      host.txb = {OP_RDSR};
      go(3);
      chk(32'({host.rxb[1], host.rxb[2]}), 32'h0C0C);
      chk(32'(host.used), (w == 1) ? 32'h3 : (w == 2) ? 32'hF : 32'h2);
    end
    wr(A_CTRL, 32'h0);
    host.wid = 2'h0;
    host.mode3 = 1'b0;
    host.txb = {OP_PP, 8'h7C, 8'h00, 8'h00, 8'h55};
    op(5, 1'b1, 8'h0C);
    host.txb = {OP_SE, 8'h7B, 8'hF0, 8'h00};
    op(4, 1'b0, 8'h0C);
    rdc(A_GEO, 32'hFFFFFFFF, 32'h007B07BF);
    host.txb = {OP_BE, 8'h10, 8'h00, 8'h00};
    op(4, 1'b0, 8'h0C);
    host.txb = {OP_CE};
    op(1, 1'b1, 8'h0C);
    host.txb = {OP_SE, 8'hFF, 8'hF1, 8'h23};
    op(4, 1'b1, 8'h0C);
    rdc(A_ADDR, 32'hFFFFFF, 32'h7FF123);
    rdc(A_GEO, 32'hFFFFFFFF, 32'h007F07FF);
    host.txb = {OP_PP, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 256; i++) host.txb.push_back(8'(i));
    op(260, 1'b0, 8'h0C);
    rdc(A_GEO, 32'hFF800000, 32'h80000000);
    rdc(A_RX, 32'h1FF, 32'h1FF);
    host.txb = {OP_WRSR, 8'h8C};
    op(2, 1'b0, 8'h8C);
    host.wp_n = 1'b0;
    host.txb = {OP_WRSR, 8'h80};
    op(2, 1'b1, 8'h8C);
    wr(A_CTRL, 32'h2);
    host.wid = 2'h2;
    op(2, 1'b0, 8'h80);
    wr(A_CTRL, 32'h0);
    host.wid = 2'h0;
    host.wp_n = 1'b1;
    host.txb = {OP_OTPP, 8'h00, 8'h00, 8'h10, 8'h5A};
    op(5, 1'b0, 8'h80);
    host.txb[4] = 8'h0F;
    op(5, 1'b0, 8'h80);
    host.txb = {OP_OTPR, 8'h00, 8'h00, 8'h10};
    go(6);
    chk(32'({host.rxb[4], host.rxb[5]}), 32'h0AFF);
    wr(A_CTRL, 32'h10);
    host.txb = {OP_OTPP, 8'h00, 8'h00, 8'h11, 8'h00};
    op(5, 1'b1, 8'h80);
    // Buffer: fill to two, stall a third push, drain through a dual read frame.
    wr(A_CTRL, 32'h1);
    rdc(A_CTRL, 32'hFFFFFFFF, 32'h11);
    host.wid = 2'h1;
    wr(A_TX, 32'hA1);
    wr(A_TX, 32'hB2);
    rdc(A_TX, 32'h3, 32'h2);
    host.txb = {OP_READ, 8'h00, 8'h00, 8'h00};
    fork
      wr(A_TX, 32'hC3);
      go(8);
    join
    chk({host.rxb[4], host.rxb[5], host.rxb[6], host.rxb[7]}, 32'hA1B2C3FF);
    rdc(A_TX, 32'h3, 32'h0);
    conclude();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    #400000;
    n_fail++;
    conclude();
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
endmodule : tb_top
